// *** core/psu_mgmt_slave.sv ***
// Management link target of a power supply: two-wire bus slave with PEC, status, alert.
// Assumes scl/sda and straps come from pins; Wishbone master on clk_i.
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "psu_map.svh"
module psu_mgmt_slave #(
	parameter int BLK_DEPTH = 16
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  scl_i,
	input  wire logic                  sda_i,
	output logic                       sda_o,
	output logic                       sda_oe_n_o,
	output logic                       smb_alert_n_o,
	input  wire logic                  output_control_pin_i,
	output logic                       output_enable_o,
	input  wire psu_pkg::strap_level_t addr_strap_low_i,
	input  wire psu_pkg::strap_level_t addr_strap_high_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o
);
	import psu_pkg::*;
	localparam int AW = $clog2(BLK_DEPTH);
	localparam logic [5:0] DEPTH6 = 6'(BLK_DEPTH);

	if (BLK_DEPTH < 2 || BLK_DEPTH > 32) begin : g_chk
		$error("psu_mgmt_slave: BLK_DEPTH must be 2..32");
	end

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ `CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction

	function automatic logic [1:0] strap_dec(input strap_level_t t);
		unique case (t)
			3'b111:  return 2'b00;
			3'b011:  return 2'b01;
			3'b001:  return 2'b10;
			default: return 2'b11;
		endcase
	endfunction

	function automatic logic [15:0] lin_word(input logic [4:0] e, input logic [10:0] m);
		return {e, m};
	endfunction

	// Pin synchronisers
	logic [8:0] sync1_reg, sync2_reg;
	logic       scl_d_reg, sda_d_reg;
	always_ff @(posedge clk_i) begin
		sync1_reg <= {scl_i, sda_i, output_control_pin_i, addr_strap_high_i, addr_strap_low_i};
		sync2_reg <= sync1_reg;
		scl_d_reg <= sync2_reg[8];
		sda_d_reg <= sync2_reg[7];
	end
	logic scl_s, sda_s, ctl_s, scl_rise, scl_fall, start_c, stop_c;
	logic [3:0] addr4;
	assign scl_s    = sync2_reg[8];
	assign sda_s    = sync2_reg[7];
	assign ctl_s    = sync2_reg[6];
	assign addr4    = {strap_dec(sync2_reg[5:3]), strap_dec(sync2_reg[2:0])};
	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	// Link engine state
	link_state_t st_reg, st_next;
	logic [3:0]  bits_reg, bits_next;
	logic [7:0]  sh_reg, sh_next, crc_reg, crc_next, cmd_reg, cmd_next;
	logic [7:0]  d0_reg, d0_next, d1_reg, d1_next, blk_len_reg, blk_len_next;
	logic [5:0]  byte_n_reg, byte_n_next, rd_len_reg, rd_len_next, rd_idx_reg, rd_idx_next;
	logic [15:0] rdw_reg, rdw_next;
	logic        rd_reg, rd_next, acked_reg, acked_next, mack_reg, mack_next;
	logic        drv_reg, drv_next, cmd_ok_reg, cmd_ok_next;
	// Settings written over the link
	logic [7:0]  op_reg, op_next, ocr_reg, ocr_next, otr_reg, otr_next;
	logic [15:0] vcmd_reg, vcmd_next;
	// Events towards status
	logic        clr_ev, inv_ev, pec_ev, do_load;
	logic [7:0]  b, tx;
	logic [5:0]  wlen;
	// Firmware view and status
	logic [2:0]  cond_reg, cond_next;
	logic [15:0] telv_reg, telv_next, teli_reg, teli_next;
	logic        oc_lat_reg, oc_lat_next, ot_lat_reg, ot_lat_next;
	logic        sh_lat_reg, sh_lat_next, cml_lat_reg, cml_lat_next;
	logic [4:0]  live_prev_reg, live;
	logic        alert_reg, alert_next;
	logic [15:0] sw;
	// Read selector
	logic [15:0] sel_word;
	logic [5:0]  sel_len;

	byte_store_if #(.AW(AW)) mem_bus ();
	byte_store #(.DEPTH(BLK_DEPTH), .AW(AW)) u_store (.clk_i(clk_i), .bus(mem_bus.store));

	assign b    = {sh_reg[6:0], sda_s};
	assign wlen = byte_n_reg - 6'd3;
	assign mem_bus.raddr = AW'(rd_idx_reg - 6'd1);

	always_comb begin
		sel_word = 16'h0000;
		sel_len  = 6'd0;
		unique case (cmd_reg)
			`CMD_OPERATION: begin sel_word = {8'h00, op_reg}; sel_len = 6'd1; end
			`CMD_VOUT_MODE: begin sel_word = {11'h000, `VOUT_EXP}; sel_len = 6'd1; end
			`CMD_VOUT_CMD:  begin sel_word = vcmd_reg; sel_len = 6'd2; end
			`CMD_OC_RESP:   begin sel_word = {8'h00, ocr_reg}; sel_len = 6'd1; end
			`CMD_OT_RESP:   begin sel_word = {8'h00, otr_reg}; sel_len = 6'd1; end
			`CMD_STAT_BYTE: begin sel_word = {8'h00, sw[7:0]}; sel_len = 6'd1; end
			`CMD_STAT_WORD: begin sel_word = sw; sel_len = 6'd2; end
			`CMD_READ_VOUT: begin sel_word = telv_reg; sel_len = 6'd2; end
			`CMD_READ_IOUT: begin sel_word = lin_word(teli_reg[15:11], teli_reg[10:0]); sel_len = 6'd2; end
			`CMD_USER_BLOCK: sel_len = blk_len_reg[5:0] + 6'd1;
			default: sel_len = 6'd0;
		endcase
	end

	always_comb begin
		st_next = st_reg; bits_next = bits_reg; sh_next = sh_reg; crc_next = crc_reg;
		cmd_next = cmd_reg; d0_next = d0_reg; d1_next = d1_reg; blk_len_next = blk_len_reg;
		byte_n_next = byte_n_reg; rd_len_next = rd_len_reg; rd_idx_next = rd_idx_reg;
		rdw_next = rdw_reg; rd_next = rd_reg; acked_next = acked_reg; mack_next = mack_reg;
		drv_next = drv_reg; cmd_ok_next = cmd_ok_reg;
		op_next = op_reg; ocr_next = ocr_reg; otr_next = otr_reg; vcmd_next = vcmd_reg;
		clr_ev = 1'b0; inv_ev = 1'b0; pec_ev = 1'b0; do_load = 1'b0; tx = 8'h00;
		mem_bus.we = 1'b0; mem_bus.waddr = AW'(wlen); mem_bus.wdata = b;
		if (start_c) begin
			st_next = ST_RX; bits_next = 4'd0; byte_n_next = 6'd0; drv_next = 1'b0; rd_next = 1'b0;
			if (st_reg == ST_IDLE || st_reg == ST_WAIT) begin
				crc_next = 8'h00;
				cmd_ok_next = 1'b0;
			end
		end else if (stop_c) begin
			st_next = ST_IDLE; drv_next = 1'b0;
			if (!rd_reg && byte_n_reg >= 6'd3) begin
				if (crc_reg != 8'h00) begin
					pec_ev = 1'b1;
				end else begin
					unique case (cmd_reg)
						`CMD_CLEAR: if (wlen == 6'd0) clr_ev = 1'b1; else inv_ev = 1'b1;
						`CMD_OPERATION: if (wlen == 6'd1) op_next = d0_reg; else inv_ev = 1'b1;
						`CMD_ONOFF_CFG: inv_ev = (wlen != 6'd1) || (d0_reg != `ONOFF_FIXED);
						`CMD_VOUT_CMD: if (wlen == 6'd2) vcmd_next = {d1_reg, d0_reg}; else inv_ev = 1'b1;
						`CMD_OC_RESP: begin
							if (wlen == 6'd1 && (d0_reg == `OC_LATCH || d0_reg == `OC_HICCUP)) begin
								ocr_next = d0_reg;
							end else begin
								inv_ev = 1'b1;
							end
						end
						`CMD_OT_RESP: begin
							if (wlen == 6'd1 && (d0_reg == `OT_LATCH || d0_reg == `OT_RESTART)) begin
								otr_next = d0_reg;
							end else begin
								inv_ev = 1'b1;
							end
						end
						`CMD_USER_BLOCK: begin
							if ({2'b00, wlen} == d0_reg + 8'd1 && d0_reg != 8'h00 && d0_reg <= {2'b00, DEPTH6}) begin
								blk_len_next = d0_reg;
							end else begin
								inv_ev = 1'b1;
							end
						end
						default: inv_ev = 1'b1;
					endcase
				end
			end
		end else begin
			unique case (st_reg)
				ST_IDLE, ST_WAIT: ;
				ST_RX: begin
					if (scl_rise && bits_reg != 4'd8) begin
						sh_next = b;
						bits_next = bits_reg + 4'd1;
						if (bits_reg == 4'd7) begin
							byte_n_next = (byte_n_reg == 6'h3F) ? byte_n_reg : byte_n_reg + 6'd1;
							if (byte_n_reg == 6'd0) begin
								acked_next = 1'b0;
								if (b[7:1] == {`ADDR_PREFIX, addr4} || b[7:1] == `ADDR_BCAST) begin
									if (!b[0]) begin
										acked_next = 1'b1;
										crc_next = crc8(crc_reg, b);
									end else if (b[7:1] == `ADDR_BCAST || !cmd_ok_reg || sel_len == 6'd0) begin
										inv_ev = 1'b1;
									end else begin
										acked_next = 1'b1; rd_next = 1'b1;
										crc_next = crc8(crc_reg, b);
										rdw_next = sel_word; rd_len_next = sel_len; rd_idx_next = 6'd0;
									end
								end
							end else begin
								acked_next = 1'b1;
								crc_next = crc8(crc_reg, b);
								if (byte_n_reg == 6'd1) begin
									cmd_next = b;
									cmd_ok_next = 1'b1;
								end
								if (byte_n_reg == 6'd2) d0_next = b;
								if (byte_n_reg == 6'd3) d1_next = b;
								if (cmd_reg == `CMD_USER_BLOCK && byte_n_reg >= 6'd3 && wlen < DEPTH6) begin
									mem_bus.we = 1'b1;
								end
							end
						end
					end else if (scl_fall && bits_reg == 4'd8) begin
						st_next = ST_RACK;
						drv_next = acked_reg;
					end
				end
				ST_RACK: begin
					if (scl_fall) begin
						drv_next = 1'b0;
						if (!acked_reg) st_next = ST_WAIT;
						else if (rd_reg) do_load = 1'b1;
						else begin
							st_next = ST_RX;
							bits_next = 4'd0;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bits_reg == 4'd8) begin
							drv_next = 1'b0;
							st_next = ST_TACK;
						end else begin
							drv_next = ~sh_reg[7];
							sh_next = {sh_reg[6:0], 1'b0};
							bits_next = bits_reg + 4'd1;
						end
					end
				end
				ST_TACK: begin
					if (scl_rise) mack_next = ~sda_s;
					else if (scl_fall) begin
						if (mack_reg && rd_idx_reg <= rd_len_reg) do_load = 1'b1;
						else st_next = ST_WAIT;
					end
				end
				default: st_next = ST_IDLE;
			endcase
		end
		if (do_load) begin
			if (rd_idx_reg == rd_len_reg) tx = crc_reg;
			else if (cmd_reg == `CMD_USER_BLOCK) tx = (rd_idx_reg == 6'd0) ? blk_len_reg : mem_bus.rdata;
			else tx = (rd_idx_reg == 6'd0) ? rdw_reg[7:0] : rdw_reg[15:8];
			if (rd_idx_reg != rd_len_reg) crc_next = crc8(crc_reg, tx);
			sh_next = {tx[6:0], 1'b0}; drv_next = ~tx[7]; bits_next = 4'd1;
			rd_idx_next = rd_idx_reg + 6'd1; st_next = ST_TX;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= ST_IDLE; bits_reg <= 4'd0; sh_reg <= 8'h00; crc_reg <= 8'h00;
			cmd_reg <= 8'h00; d0_reg <= 8'h00; d1_reg <= 8'h00; blk_len_reg <= 8'h00;
			byte_n_reg <= 6'd0; rd_len_reg <= 6'd0; rd_idx_reg <= 6'd0; rdw_reg <= 16'h0000;
			rd_reg <= 1'b0; acked_reg <= 1'b0; mack_reg <= 1'b0; drv_reg <= 1'b0;
			cmd_ok_reg <= 1'b0; op_reg <= `RST_OPERATION; ocr_reg <= `RST_OC_RESP;
			otr_reg <= `RST_OT_RESP; vcmd_reg <= 16'h0000;
		end else begin
			st_reg <= st_next; bits_reg <= bits_next; sh_reg <= sh_next; crc_reg <= crc_next;
			cmd_reg <= cmd_next; d0_reg <= d0_next; d1_reg <= d1_next; blk_len_reg <= blk_len_next;
			byte_n_reg <= byte_n_next; rd_len_reg <= rd_len_next; rd_idx_reg <= rd_idx_next;
			rdw_reg <= rdw_next; rd_reg <= rd_next; acked_reg <= acked_next; mack_reg <= mack_next;
			drv_reg <= drv_next; cmd_ok_reg <= cmd_ok_next; op_reg <= op_next; ocr_reg <= ocr_next;
			otr_reg <= otr_next; vcmd_reg <= vcmd_next;
		end
	end

	// Status, alarms and alert
	assign output_enable_o = ctl_s & op_reg[7];
	assign live = {~output_enable_o, oc_lat_reg, ot_lat_reg, sh_lat_reg, cml_lat_reg};
	always_comb begin
		sw = 16'h0000;
		sw[`SW_OFF]  = ~output_enable_o;
		sw[`SW_OC]   = oc_lat_reg;
		sw[`SW_TEMP] = ot_lat_reg;
		sw[`SW_SHUT] = sh_lat_reg;
		sw[`SW_CML]  = cml_lat_reg;
		oc_lat_next  = (oc_lat_reg & ~clr_ev) | cond_reg[`COND_OC];
		ot_lat_next  = (ot_lat_reg & ~clr_ev) | cond_reg[`COND_OT];
		sh_lat_next  = (sh_lat_reg & ~clr_ev) | cond_reg[`COND_SHUT];
		cml_lat_next = (cml_lat_reg & ~clr_ev) | inv_ev | pec_ev;
		alert_next   = (alert_reg & ~clr_ev) | (live != live_prev_reg);
	end

	// Wishbone slave
	logic        ack_reg, ack_next, wr_en;
	logic [31:0] dat_reg, dat_next;
	assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
	always_comb begin
		ack_next  = wb_cyc_i & wb_stb_i & ~ack_reg;
		dat_next  = dat_reg;
		cond_next = cond_reg;
		telv_next = telv_reg;
		teli_next = teli_reg;
		if (ack_next && !wb_we_i) begin
			unique case (wb_adr_i)
				`WB_COND:   dat_next = {29'h0, cond_reg};
				`WB_STATUS: dat_next = {16'h0000, sw};
				`WB_ADDR:   dat_next = {24'h0, ~smb_alert_n_o, `ADDR_PREFIX, addr4};
				`WB_VOUT:   dat_next = {16'h0000, vcmd_reg};
				`WB_TELV:   dat_next = {16'h0000, telv_reg};
				`WB_TELI:   dat_next = {16'h0000, lin_word(teli_reg[15:11], teli_reg[10:0])};
				`WB_RESP:   dat_next = {8'h00, op_reg, otr_reg, ocr_reg};
				default:    dat_next = 32'h0000_0000;
			endcase
		end
		if (wr_en) begin
			unique case (wb_adr_i)
				`WB_COND: if (wb_sel_i[0]) cond_next = wb_dat_i[2:0];
				`WB_TELV: telv_next = {wb_sel_i[1] ? wb_dat_i[15:8] : telv_reg[15:8],
					wb_sel_i[0] ? wb_dat_i[7:0] : telv_reg[7:0]};
				`WB_TELI: teli_next = {wb_sel_i[1] ? wb_dat_i[15:8] : teli_reg[15:8],
					wb_sel_i[0] ? wb_dat_i[7:0] : teli_reg[7:0]};
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oc_lat_reg <= 1'b0; ot_lat_reg <= 1'b0; sh_lat_reg <= 1'b0; cml_lat_reg <= 1'b0;
			live_prev_reg <= 5'h00; alert_reg <= 1'b1;
			ack_reg <= 1'b0; dat_reg <= 32'h0000_0000; cond_reg <= 3'h0;
			telv_reg <= 16'h0000; teli_reg <= 16'h0000;
		end else begin
			oc_lat_reg <= oc_lat_next; ot_lat_reg <= ot_lat_next;
			sh_lat_reg <= sh_lat_next; cml_lat_reg <= cml_lat_next;
			live_prev_reg <= live; alert_reg <= alert_next;
			ack_reg <= ack_next; dat_reg <= dat_next; cond_reg <= cond_next;
			telv_reg <= telv_next; teli_reg <= teli_next;
		end
	end

	assign sda_o         = 1'b0;
	assign sda_oe_n_o    = ~drv_reg;
	assign smb_alert_n_o = ~alert_reg;
	assign wb_ack_o      = ack_reg;
	assign wb_dat_o      = dat_reg;
endmodule
`default_nettype wire

// *** core/psu_map.svh ***
// Constants of the power supply management slave: bus offsets, fields, codes, resets.
// Assumes inclusion by bare name from the design files.
`ifndef PSU_MAP_SVH
`define PSU_MAP_SVH
// Wishbone byte offsets
`define WB_COND         8'h00
`define WB_STATUS       8'h04
`define WB_ADDR         8'h08
`define WB_VOUT         8'h0C
`define WB_TELV         8'h10
`define WB_TELI         8'h14
`define WB_RESP         8'h18
// Condition register fields
`define COND_OC         0
`define COND_OT         1
`define COND_SHUT       2
// Status word fields
`define SW_CML          1
`define SW_TEMP         2
`define SW_OC           4
`define SW_SHUT         5
`define SW_OFF          6
// Link addressing
`define ADDR_PREFIX     3'b110
`define ADDR_BCAST      7'h00
// Commands
`define CMD_OPERATION   8'h01
`define CMD_ONOFF_CFG   8'h02
`define CMD_CLEAR       8'h03
`define CMD_VOUT_MODE   8'h20
`define CMD_VOUT_CMD    8'h21
`define CMD_OC_RESP     8'h47
`define CMD_OT_RESP     8'h50
`define CMD_STAT_BYTE   8'h78
`define CMD_STAT_WORD   8'h79
`define CMD_READ_VOUT   8'h8B
`define CMD_READ_IOUT   8'h8C
`define CMD_USER_BLOCK  8'hB0
// Accepted codes and fixed values
`define ONOFF_FIXED     8'h1D
`define OC_LATCH        8'hC0
`define OC_HICCUP       8'hF8
`define OT_LATCH        8'h80
`define OT_RESTART      8'hC0
`define VOUT_EXP        5'h09
`define CRC_POLY        8'h07
// Reset values
`define RST_OPERATION   8'h80
`define RST_OC_RESP     8'hF8
`define RST_OT_RESP     8'hC0
`endif

// *** core/psu_pkg.sv ***
// Types of the power supply management slave.
// Assumes nothing of its surroundings.
package psu_pkg;
	typedef logic [2:0] strap_level_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_RACK = 3'b011,
		ST_TX   = 3'b010,
		ST_TACK = 3'b110,
		ST_WAIT = 3'b111
	} link_state_t;
endpackage

// *** core/byte_store_if.sv ***
// Carrier between the link engine and its block byte store.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface byte_store_if #(parameter int AW = 4);
	logic          we;
	logic [AW-1:0] waddr;
	logic [7:0]    wdata;
	logic [AW-1:0] raddr;
	logic [7:0]    rdata;
	modport engine (output we, output waddr, output wdata, output raddr, input rdata);
	modport store  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// *** core/byte_store.sv ***
// Small byte memory holding the user block; read data leave a register.
// Assumes the engine holds raddr stable a cycle before it uses rdata.
`timescale 1ns/1ps
`default_nettype none
module byte_store #(
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic    clk_i,
	byte_store_if.store  bus
);
	logic [7:0] mem [DEPTH];
	logic [7:0] rdata_reg;

	if (DEPTH < 2 || (1 << AW) < DEPTH) begin : g_chk
		$error("byte_store: DEPTH does not fit AW");
	end

	always_ff @(posedge clk_i) begin
		if (bus.we) begin
			mem[bus.waddr] <= bus.wdata;
		end
		rdata_reg <= mem[bus.raddr];
	end

	assign bus.rdata = rdata_reg;
endmodule
`default_nettype wire

// *** bench/psu_mgmt_slave_properties.sv ***
// Checker of the management slave ports: link drive timing, readback, codes, latches.
// Assumes binding onto psu_mgmt_slave, one clock domain on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "psu_map.svh"
module psu_mgmt_slave_properties (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  scl_i,
	input wire logic                  sda_oe_n_o,
	input wire logic                  smb_alert_n_o,
	input wire logic                  output_control_pin_i,
	input wire logic                  output_enable_o,
	input wire psu_pkg::strap_level_t addr_strap_low_i,
	input wire psu_pkg::strap_level_t addr_strap_high_i,
	input wire logic                  wb_we_i,
	input wire logic [7:0]            wb_adr_i,
	input wire logic [3:0]            wb_sel_i,
	input wire logic [31:0]           wb_dat_i,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_ack_o
);
	import psu_pkg::*;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic       cond_oc_reg;
	logic       cond_oc_next;
	logic       rd_ack;
	logic [6:0] addr_exp;
	assign rd_ack = wb_ack_o && !wb_we_i;
	assign addr_exp = {`ADDR_PREFIX, 2'(3 - $countones(addr_strap_high_i)),
		2'(3 - $countones(addr_strap_low_i))};
	// Tracks the overcurrent condition written by software
	always_comb begin
		cond_oc_next = cond_oc_reg;
		if (wb_ack_o && wb_we_i && wb_adr_i == `WB_COND && wb_sel_i[0])
			cond_oc_next = wb_dat_i[`COND_OC];
		if (rst_i)
			cond_oc_next = 1'b0;
	end
	always_ff @(posedge clk_i) begin
		cond_oc_reg <= cond_oc_next;
	end
	addr_decode_a: assert property (rd_ack && wb_adr_i == `WB_ADDR
		|-> wb_dat_o[6:0] == addr_exp) else $error("Address differs from straps");
	pin_off_a: assert property (!output_control_pin_i [*4] |-> !output_enable_o)
		else $error("Output on with pin low");
	pin_follow_a: assert property ($fell(output_control_pin_i)
		|-> ##[1:4] !output_enable_o) else $error("Output state not refreshed");
	drive_edge_a: assert property ($changed(sda_oe_n_o) |-> !scl_i)
		else $error("Data drive changed with clock high");
	ack_hold_a: assert property ($fell(sda_oe_n_o) |=> !sda_oe_n_o [*4])
		else $error("Driven bit released too early");
	oc_code_a: assert property (rd_ack && wb_adr_i == `WB_RESP
		|-> wb_dat_o[7:0] inside {`OC_LATCH, `OC_HICCUP}) else $error("Bad overcurrent code");
	ot_code_a: assert property (rd_ack && wb_adr_i == `WB_RESP
		|-> wb_dat_o[15:8] inside {`OT_LATCH, `OT_RESTART}) else $error("Bad temperature code");
	alert_boot_a: assert property ($fell(rst_i) |-> !smb_alert_n_o)
		else $error("Alert not raised after reset");
	oc_latch_a: assert property (rd_ack && wb_adr_i == `WB_STATUS && cond_oc_reg
		|-> wb_dat_o[`SW_OC]) else $error("Overcurrent bit missing");
	cover property (rd_ack && wb_adr_i == `WB_STATUS);
	cover property ($fell(sda_oe_n_o));
	cover property ($rose(smb_alert_n_o));
endmodule
bind psu_mgmt_slave psu_mgmt_slave_properties u_props (.clk_i, .rst_i, .scl_i, .sda_oe_n_o,
	.smb_alert_n_o, .output_control_pin_i, .output_enable_o, .addr_strap_low_i,
	.addr_strap_high_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
`default_nettype wire

// *** bench/smb_host_model.sv ***
// Host controller model of the two-wire link: frames, bytes and PEC.
// Assumes a pull-up on data; clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module smb_host_model (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	logic [7:0] crc = 8'h00;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tick();
		repeat (4) @(posedge clk_i);
	endtask
	// Running PEC over every byte of the message
	task automatic crc_add(input logic [7:0] b);
		crc = crc ^ b;
		repeat (8) crc = crc[7] ? ((crc << 1) ^ 8'h07) : (crc << 1);
	endtask
	task automatic bitio(input logic b, output logic r);
		sda_o <= b;
		tick();
		scl_o <= 1'b1;
		tick();
		r = sda_i;
		tick();
		scl_o <= 1'b0;
		tick();
	endtask
	// Start or repeated start; PEC restarts only with a fresh message
	task automatic start(input logic fresh);
		if (fresh)
			crc = 8'h00;
		sda_o <= 1'b1;
		tick();
		scl_o <= 1'b1;
		tick();
		sda_o <= 1'b0;
		tick();
		scl_o <= 1'b0;
		tick();
	endtask
	task automatic stop();
		sda_o <= 1'b0;
		tick();
		scl_o <= 1'b1;
		tick();
		sda_o <= 1'b1;
		tick();
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		crc_add(b);
		for (int i = 7; i >= 0; i--)
			bitio(b[i], r);
		bitio(1'b1, r);
		ack = !r;
	endtask
	// Acknowledges data, refuses the last byte (the PEC)
	task automatic rbyte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitio(1'b1, b[i]);
		bitio(last, r);
		crc_add(b);
	endtask
endmodule
`default_nettype wire

// *** bench/psu_pmbus_slave_frames_test.sv ***
// Testbench of the management slave: link frames through the host model, registers on Wishbone.
// Assumes design files, host model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "psu_map.svh"
module psu_pmbus_slave_frames_test;
	localparam logic [6:0] DEV = {`ADDR_PREFIX, 4'b1001};
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        pin = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hF;
	logic [3:0]  msk = 4'hF;
	logic [2:0]  lo = 3'b011;
	logic [2:0]  hi = 3'b001;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic [31:0] q;
	logic        ack, scl, hsda, sda_line, sda_d, oe_n, alert_n, out_en, ok;
	logic [7:0]  cv [6] = '{8'hC0, 8'h55, 8'hF8, 8'h80, 8'h12, 8'hC0};
	logic [7:0]  fx [3] = '{8'h02, 8'h19, 8'h98};
	logic [7:0]  oc_e, ot_e;
	int          num_errors = 0;
	int          n_checks = 0;
	always #2.5 clk_i = ~clk_i;
	assign sda_line = hsda & (oe_n | sda_d);
	psu_mgmt_slave u_dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_d), .sda_oe_n_o(oe_n), .smb_alert_n_o(alert_n), .output_control_pin_i(pin),
		.output_enable_o(out_en), .addr_strap_low_i(lo), .addr_strap_high_i(hi),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
	smb_host_model u_host (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_o(hsda));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= msk;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
	endtask
	// PEC mode m: 0 none, 1 good, 2 corrupted
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input int n,
		input logic [31:0] d, input logic [1:0] m);
		logic k;
		u_host.start(1'b1);
		u_host.wbyte({a, 1'b0}, ok);
		u_host.wbyte(c, k);
		ok = ok & k;
		for (int i = 0; i < n; i++) begin
			u_host.wbyte(d[8*i+:8], k);
			ok = ok & k;
		end
		if (m != 2'd0) begin
			u_host.wbyte(m == 2'd1 ? u_host.crc : ~u_host.crc, k);
			ok = ok & k;
		end
		u_host.stop();
		repeat (8) @(posedge clk_i);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] c, input int n);
		logic       k;
		logic [7:0] b;
		q = 32'h0000_0000;
		u_host.start(1'b1);
		u_host.wbyte({a, 1'b0}, k);
		u_host.wbyte(c, k);
		u_host.start(1'b0);
		u_host.wbyte({a, 1'b1}, ok);
		if (ok) begin
			for (int i = 0; i < n; i++) begin
				u_host.rbyte(1'b0, b);
				q[8*i+:8] = b;
			end
			u_host.rbyte(1'b1, b);
			chk(u_host.crc, 0);
		end
		u_host.stop();
		repeat (8) @(posedge clk_i);
	endtask
	task automatic results();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(alert_n, 1'b0);
		wb(1'b0, `WB_ADDR, 0);
		chk(q[6:0], DEV);
		wr(DEV, `CMD_CLEAR, 0, 0, 2'd1);
		chk(alert_n, 1'b1);
		wr(DEV, `CMD_OPERATION, 1, 0, 2'd1);
		chk(out_en, 1'b0);
		rd(DEV, `CMD_STAT_WORD, 2);
		chk(ok, 1'b1);
		chk(q[`SW_OFF], 1'b1);
		wr(DEV, `CMD_OPERATION, 1, 32'h0000_0080, 2'd1);
		chk(out_en, 1'b1);
		pin <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk(out_en, 1'b0);
		pin <= 1'b1;
		wr(DEV, `CMD_OPERATION, 1, 0, 2'd0);
		chk(out_en, 1'b1);
		wr(DEV, `CMD_OPERATION, 1, 0, 2'd2);
		chk(out_en, 1'b1);
		rd(DEV, `CMD_STAT_WORD, 2);
		chk(q[`SW_CML], 1'b1);
		chk(alert_n, 1'b0);
		wb(1'b1, `WB_TELI, 32'h0000_E2A5);
		rd(DEV, `CMD_READ_IOUT, 2);
		chk(q, 32'h0000_E2A5);
		wb(1'b1, `WB_TELV, 32'h0000_1234);
		rd(DEV, `CMD_READ_VOUT, 2);
		chk(q, 32'h0000_1234);
		rd(DEV, `CMD_VOUT_MODE, 1);
		chk(q, 32'h0000_0009);
		for (int i = 0; i < 3; i++) begin
			rd(DEV, fx[i], 2);
			chk(ok, 1'b0);
		end
		wr(DEV, `CMD_CLEAR, 0, 0, 2'd1);
		rd(7'h00, `CMD_STAT_WORD, 2);
		chk(ok, 1'b0);
		rd(DEV, `CMD_STAT_WORD, 2);
		chk(q[`SW_CML], 1'b1);
		oc_e = `RST_OC_RESP;
		ot_e = `RST_OT_RESP;
		for (int i = 0; i < 6; i++) begin
			wr(DEV, i < 3 ? `CMD_OC_RESP : `CMD_OT_RESP, 1, {24'h00_0000, cv[i]}, 2'd1);
			if (i < 3 && cv[i] inside {8'hC0, 8'hF8})
				oc_e = cv[i];
			if (i >= 3 && cv[i] inside {8'h80, 8'hC0})
				ot_e = cv[i];
			wb(1'b0, `WB_RESP, 0);
			chk(q[15:0], {ot_e, oc_e});
		end
		wb(1'b1, `WB_COND, 32'h0000_0001);
		wb(1'b1, `WB_COND, 0);
		rd(DEV, `CMD_STAT_WORD, 2);
		chk(q[`SW_OC], 1'b1);
		wr(DEV, `CMD_CLEAR, 0, 0, 2'd1);
		rd(DEV, `CMD_STAT_WORD, 2);
		chk(q[`SW_OC], 1'b0);
		wb(1'b1, `WB_COND, 32'h0000_0001);
		wr(DEV, `CMD_CLEAR, 0, 0, 2'd1);
		rd(DEV, `CMD_STAT_WORD, 2);
		chk(q[`SW_OC], 1'b1);
		wb(1'b0, `WB_STATUS, 0);
		chk(q[`SW_OC], 1'b1);
		wb(1'b1, `WB_COND, 0);
		wr(DEV, `CMD_USER_BLOCK, 4, 32'hC3B2_A103, 2'd1);
		chk(ok, 1'b1);
		rd(DEV, `CMD_USER_BLOCK, 4);
		chk(q, 32'hC3B2_A103);
		msk = 4'h1;
		wb(1'b1, `WB_TELV, 32'h0000_FF77);
		msk = 4'hF;
		wb(1'b0, `WB_TELV, 0);
		chk(q, 32'h0000_1277);
		wr(DEV, `CMD_VOUT_CMD, 2, 32'h0000_3412, 2'd1);
		wb(1'b0, `WB_VOUT, 0);
		chk(q, 32'h0000_3412);
		wr(DEV, `CMD_CLEAR, 0, 0, 2'd1);
		wr(DEV, `CMD_ONOFF_CFG, 1, {24'h00_0000, `ONOFF_FIXED}, 2'd1);
		wb(1'b0, `WB_STATUS, 0);
		chk(q[`SW_CML], 1'b0);
		lo <= 3'b111;
		hi <= 3'b000;
		wr(7'h00, `CMD_OPERATION, 1, 0, 2'd1);
		chk(ok, 1'b1);
		chk(out_en, 1'b0);
		wb(1'b0, `WB_ADDR, 0);
		chk(q[6:0], {`ADDR_PREFIX, 4'hC});
		results();
	end
	initial begin
		#300_000;
		num_errors++;
		results();
	end
endmodule
`default_nettype wire
